// file: src/iop_map.vh
// register offsets, field positions and reset values of the port block
`ifndef IOP_MAP_VH
`define IOP_MAP_VH
`define IOP_FUNC_SEL_ADDR 16'hffc9
`define IOP_DRAIN_SEL_ADDR 16'hffcb
`define IOP_DATA_LATCH_ADDR 16'hffd5
`define IOP_DIRECTION_ADDR 16'hffe5
`define IOP_P1_DIR_ADDR 16'hffe4
`define IOP_P1_PULLUP_ADDR 16'hffe0
`define IOP_LOW_POWER_ADDR 16'hffe8
`define IOP_FUNC_SEL_RESET 8'hc0
`define IOP_DRAIN_SEL_RESET 8'h00
`define IOP_DATA_LATCH_RESET 8'h00
`define IOP_DIRECTION_RESET 8'h00
`define IOP_P1_DIR_RESET 8'h00
`define IOP_P1_PULLUP_RESET 8'h00
`define IOP_FUNC_FIXED_MASK 8'hc0
`define IOP_FUNC_WRITE_MASK 8'h0f
`define IOP_FUNC_REDUCED_MASK 8'h09
`define IOP_P1_REDUCED_MASK 8'ha7
`define IOP_FULL_MASK 8'hff
`define IOP_FUNC_INT4_BIT 0
`define IOP_FUNC_CDIR_BIT 1
`define IOP_FUNC_PMOS_BIT 2
`define IOP_FUNC_INT0_BIT 3
`endif

// file: src/iop_port.v
// port 1 pull-up logic and port 2 general purpose i/o with apb registers
//
// Contract
// - port 1 pull-up on only when direction is 0 and pull-up bit is 1
// - all port 1 pull-ups are off after reset
// - full variant: all eight pull-ups; reduced variant: bits 7, 5, 2-0
// - in standby a floating port 1 pin drives high when pull-up is on
// - port 2 is eight bidirectional pins, 7 down to 0
// - port 2 read returns latch value where direction bit is 1
// - port 2 read returns pin level where direction bit is 0
// - port 2 data latch clears to zero on reset
// - direction bit 1 makes the pin an output, 0 an input
// - direction and latch govern a pin only while selected as general i/o
// - port 2 direction register is write-only and reads as all ones
// - port 2 direction clears to zero on reset, all pins inputs
// - function select register resets to c0
// - function select picks alternates for p2.0, p2.1, p4.3 and serial pmos
// - reduced variant lacks counter-direction select and serial pmos bit
// - bit3 int0, bit2 pmos off, bit1 count dir, bit0 int4; 7,6 fixed 1
// - drain select bit 1 gives open-drain output on a general i/o pin, 0 push-pull
`timescale 1ns/1ps
`include "iop_map.vh"
module iop_port #(
    parameter FULL_VARIANT = 1
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [7:0] port1_pin_in,
    input wire [7:0] port1_drive_oe,
    output reg [7:0] port1_pullup_on,
    output reg [7:0] port1_standby_high,
    input wire [7:0] port2_pin_in,
    output reg [7:0] port2_pin_out,
    output reg [7:0] port2_pin_oe,
    input wire [7:0] port2_alt_out,
    input wire [7:0] port2_alt_oe,
    output reg ext_int_zero_select,
    output reg ext_int_four_select,
    output reg count_dir_input,
    output reg serial_out_pmos_off
);
    localparam [7:0] P1_MASK = FULL_VARIANT ? `IOP_FULL_MASK :
        `IOP_P1_REDUCED_MASK;
    localparam [7:0] FUNC_MASK = FULL_VARIANT ? `IOP_FUNC_WRITE_MASK :
        `IOP_FUNC_REDUCED_MASK;

    reg [7:0] port1_direction_bits;
    reg [7:0] port1_pullup_control;
    reg standby_mode;
    reg [7:0] port2_data_latch;
    reg [7:0] port2_direction;
    reg [7:0] port2_function_select;
    reg [7:0] port2_drain_select;

    wire wr_en = psel & penable & pwrite;
    wire rd_setup = psel & ~penable & ~pwrite;
    wire [7:0] wd = pwdata[7:0];
    reg hit;
    reg [7:0] rd_val;
    reg [7:0] next_p1_dir;
    reg [7:0] next_p1_pu;
    reg next_standby;
    reg [7:0] next_latch;
    reg [7:0] next_dir;
    reg [7:0] next_func;
    reg [7:0] next_drain;
    reg [7:0] gpio_sel;
    reg [7:0] next_pin_out;
    reg [7:0] next_pin_oe;
    reg [7:0] next_pu;

    // register map, byte addresses, low byte lane only
    // ffe4 port 1 direction
    // ffe0 port 1 pull-up control
    // ffe8 standby control, bit 0
    // ffd5 port 2 data latch, reads pins where direction is 0
    // ffe5 port 2 direction, write-only
    // ffc9 port 2 function select, bits 7 and 6 fixed
    // ffcb port 2 drain select

    // read mux and address decode
    always @* begin
        hit = 1'b1;
        rd_val = 8'h00;
        case (paddr)
            `IOP_P1_DIR_ADDR: begin
                rd_val = port1_direction_bits;
            end
            `IOP_P1_PULLUP_ADDR: begin
                rd_val = port1_pullup_control;
            end
            `IOP_LOW_POWER_ADDR: begin
                rd_val = {7'h00, standby_mode};
            end
            `IOP_DATA_LATCH_ADDR: begin
                rd_val = (port2_direction & port2_data_latch) |
                    (~port2_direction & port2_pin_in);
            end
            `IOP_DIRECTION_ADDR: begin
                rd_val = `IOP_FULL_MASK;
            end
            `IOP_FUNC_SEL_ADDR: begin
                rd_val = port2_function_select;
            end
            `IOP_DRAIN_SEL_ADDR: begin
                rd_val = port2_drain_select;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // one write strobe per register, high in the access cycle
    wire wr_p1_dir = wr_en & (paddr == `IOP_P1_DIR_ADDR);
    wire wr_p1_pu = wr_en & (paddr == `IOP_P1_PULLUP_ADDR);
    wire wr_standby = wr_en & (paddr == `IOP_LOW_POWER_ADDR);
    wire wr_latch = wr_en & (paddr == `IOP_DATA_LATCH_ADDR);
    wire wr_dir = wr_en & (paddr == `IOP_DIRECTION_ADDR);
    wire wr_func = wr_en & (paddr == `IOP_FUNC_SEL_ADDR);
    wire wr_drain = wr_en & (paddr == `IOP_DRAIN_SEL_ADDR);

    // next register values
    always @* begin
        next_p1_dir = port1_direction_bits;
        next_p1_pu = port1_pullup_control;
        next_standby = standby_mode;
        next_latch = port2_data_latch;
        next_dir = port2_direction;
        next_func = port2_function_select;
        next_drain = port2_drain_select;
        if (wr_p1_dir) begin
            next_p1_dir = wd;
        end
        if (wr_p1_pu) begin
            next_p1_pu = wd & P1_MASK;
        end
        if (wr_standby) begin
            next_standby = wd[0];
        end
        if (wr_latch) begin
            next_latch = wd;
        end
        if (wr_dir) begin
            next_dir = wd;
        end
        if (wr_func) begin
            next_func = `IOP_FUNC_FIXED_MASK | (wd & FUNC_MASK);
        end
        if (wr_drain) begin
            next_drain = wd;
        end
    end

    // which port 2 pins are general i/o
    always @* begin
        gpio_sel = 8'hff;
        gpio_sel[0] = ~next_func[`IOP_FUNC_INT4_BIT];
        gpio_sel[1] = ~next_func[`IOP_FUNC_CDIR_BIT];
    end

    genvar i;

    // port 1 pull-up per pin; pins without pull-up hardware stay off
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_pullup
            always @* begin
                if (P1_MASK[i]) begin
                    next_pu[i] = next_p1_pu[i] & ~next_p1_dir[i];
                end else begin
                    next_pu[i] = 1'b0;
                end
            end
            // floating pin held high by its pull-up in standby
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    port1_standby_high[i] <= 1'b0;
                end else begin
                    port1_standby_high[i] <= next_standby & next_pu[i] &
                        ~port1_drive_oe[i];
                end
            end
        end
    endgenerate

    // per pin: general i/o or alternate function, then drive style
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_pin
            wire d_out;
            wire d_oe;
            wire od;
            assign d_out = gpio_sel[i] ? next_latch[i] : port2_alt_out[i];
            assign d_oe = gpio_sel[i] ? next_dir[i] :
                port2_alt_oe[i];
            // open drain only for general i/o: drive low, release high
            assign od = gpio_sel[i] & next_drain[i];
            always @* begin
                if (od) begin
                    next_pin_out[i] = 1'b0;
                    next_pin_oe[i] = d_oe & ~d_out;
                end else begin
                    next_pin_out[i] = d_out;
                    next_pin_oe[i] = d_oe;
                end
            end
        end
    endgenerate

    // pins follow the value being written at the same edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port2_pin_out <= 8'h00;
            port2_pin_oe <= 8'h00;
        end else begin
            port2_pin_out <= next_pin_out;
            port2_pin_oe <= next_pin_oe;
        end
    end

    // port 1 direction
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port1_direction_bits <= `IOP_P1_DIR_RESET;
        end else begin
            port1_direction_bits <= next_p1_dir;
        end
    end

    // port 1 pull-up control
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port1_pullup_control <= `IOP_P1_PULLUP_RESET;
        end else begin
            port1_pullup_control <= next_p1_pu;
        end
    end

    // standby control
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            standby_mode <= 1'b0;
        end else begin
            standby_mode <= next_standby;
        end
    end

    // port 2 data latch
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port2_data_latch <= `IOP_DATA_LATCH_RESET;
        end else begin
            port2_data_latch <= next_latch;
        end
    end

    // port 2 direction
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port2_direction <= `IOP_DIRECTION_RESET;
        end else begin
            port2_direction <= next_dir;
        end
    end

    // port 2 function select
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port2_function_select <= `IOP_FUNC_SEL_RESET;
        end else begin
            port2_function_select <= next_func;
        end
    end

    // port 2 drain select
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port2_drain_select <= `IOP_DRAIN_SEL_RESET;
        end else begin
            port2_drain_select <= next_drain;
        end
    end

    // port 1 pull-up outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port1_pullup_on <= 8'h00;
        end else begin
            port1_pullup_on <= next_pu;
        end
    end

    // external interrupt pin selects as levels
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_int_zero_select <= 1'b0;
            ext_int_four_select <= 1'b0;
        end else begin
            ext_int_zero_select <= next_func[`IOP_FUNC_INT0_BIT];
            ext_int_four_select <= next_func[`IOP_FUNC_INT4_BIT];
        end
    end

    // counter direction and serial pmos controls as levels
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_dir_input <= 1'b0;
            serial_out_pmos_off <= 1'b0;
        end else begin
            count_dir_input <= next_func[`IOP_FUNC_CDIR_BIT];
            serial_out_pmos_off <= next_func[`IOP_FUNC_PMOS_BIT];
        end
    end

    // zero wait state slave: ready in the access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & ~penable;
        end
    end

    // unmapped address answered with an error beside ready
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel & ~penable & ~hit;
        end
    end

    // read data captured at the setup edge, held until the next read
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            prdata <= {24'h000000, rd_val};
        end
    end
endmodule

// file: sim/iop_port_assertions.sv
// checker for the port block registers and pins
`timescale 1ns/1ps
module iop_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [7:0] port1_pullup_on,
    input wire [7:0] port2_pin_oe,
    input wire [7:0] port2_alt_oe,
    input wire ext_int_four_select
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd = pready && !pwrite;
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("long ready");
    property p_dir; rd && paddr == 16'hffe5 |-> prdata == 32'hff; endproperty
    a_dir: assert property (p_dir) else $error("dir read");
    property p_fn; rd && paddr == 16'hffc9 |-> prdata[7:6] == 2'b11;
    endproperty
    a_fn: assert property (p_fn) else $error("fixed bits");
    property p_bad; pready && paddr == 16'hff00 |-> pslverr; endproperty
    a_bad: assert property (p_bad) else $error("no error");
    property p_rst; $rose(presetn) |-> {port1_pullup_on, port2_pin_oe} == 0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset pins");
    property p_sel; psel && penable && pwrite && paddr == 16'hffc9
        |=> ext_int_four_select == $past(pwdata[0]); endproperty
    a_sel: assert property (p_sel) else $error("select bit");
    property p_alt; ext_int_four_select && $past(ext_int_four_select)
        && $stable(port2_alt_oe) |-> port2_pin_oe[0] == port2_alt_oe[0];
    endproperty
    a_alt: assert property (p_alt) else $error("alt pin");
    cover property (rd && paddr == 16'hffd5);
    cover property (pslverr);
    cover property (ext_int_four_select);
endmodule
bind iop_port iop_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port1_pullup_on(port1_pullup_on), .port2_pin_oe(port2_pin_oe),
    .port2_alt_oe(port2_alt_oe), .ext_int_four_select(ext_int_four_select));

// file: sim/iop_board.sv
// board model resolving port 2 pins against outside drivers
`timescale 1ns/1ps
module iop_board (
    input wire [7:0] port2_pin_out,
    input wire [7:0] port2_pin_oe,
    input wire [7:0] board_level,
    output wire [7:0] port2_pin_in
);
    // undriven pins settle to the board level
    assign port2_pin_in = (port2_pin_out & port2_pin_oe) |
        (board_level & ~port2_pin_oe);
endmodule

// file: sim/tb_top.sv
// self-checking bench for the port block
`timescale 1ns/1ps
module tb_top;
    reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    reg [15:0] paddr = 0;
    reg [31:0] pwdata = 0, rd;
    reg [7:0] p1oe = 8'h30, aout = 8'h01, aoe = 8'h01;
    wire [31:0] prdata;
    wire pready, pslverr, i0, i4, cd, po;
    wire [7:0] pu, sh, pin, pout, poe;
    integer mismatches = 0, check_count = 0, i;
    reg [47:0] rows [0:4];
    always #5 pclk = ~pclk;
    iop_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port1_pin_in(8'h00), .port1_drive_oe(p1oe), .port1_pullup_on(pu),
        .port1_standby_high(sh), .port2_pin_in(pin), .port2_pin_out(pout),
        .port2_pin_oe(poe), .port2_alt_out(aout), .port2_alt_oe(aoe),
        .ext_int_zero_select(i0), .ext_int_four_select(i4),
        .count_dir_input(cd), .serial_out_pmos_off(po));
    iop_board u_board (.port2_pin_out(pout), .port2_pin_oe(poe),
        .board_level(8'h55), .port2_pin_in(pin));
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
            end
        end
    endtask
    task apb(input [15:0] a, input w, input [7:0] d);
        integer n;
        begin
            @(posedge pclk);
            psel <= 1;
            pwrite <= w;
            paddr <= a;
            pwdata <= {24'h0, d};
            @(posedge pclk);
            penable <= 1;
            n = 0;
            @(negedge pclk);
            while (pready !== 1'b1 && n < 20) begin
                @(negedge pclk);
                n = n + 1;
            end
            if (pready !== 1'b1)
                mismatches = mismatches + 1;
            rd = prdata;
            err = pslverr;
            @(posedge pclk);
            psel <= 0;
            penable <= 0;
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", check_count, mismatches);
            if (mismatches == 0 && check_count > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial begin
        #100000;
        mismatches = mismatches + 1;
        end_sim;
    end
    initial begin
        rows[0] = {16'hffd5, 8'haa, 16'hffd5, 8'haa};
        rows[1] = {16'hffe5, 8'h0f, 16'hffd5, 8'h5a};
        rows[2] = {16'hffcb, 8'h3c, 16'hffcb, 8'h3c};
        rows[3] = {16'hffc9, 8'hff, 16'hffc9, 8'hcf};
        rows[4] = {16'hffc9, 8'h00, 16'hffc9, 8'hc0};
        repeat (4) @(posedge pclk);
        presetn <= 1;
        @(negedge pclk);
        chk({pu, poe}, 0);
        apb(16'hffc9, 0, 0);
        chk(rd, 32'hc0);
        apb(16'hffcb, 0, 0);
        chk(rd, 0);
        apb(16'hffe5, 1, 8'hff);
        apb(16'hffd5, 0, 0);
        chk(rd, 0);
        $display("reset test done");
        for (i = 0; i < 5; i = i + 1) begin
            apb(rows[i][47:32], 1, rows[i][31:24]);
            apb(rows[i][23:8], 0, 0);
            chk(rd, {24'h0, rows[i][7:0]});
        end
        $display("table test done");
        apb(16'hffcb, 1, 0);
        apb(16'hffe5, 1, 8'hff);
        @(negedge pclk);
        chk({poe, pout}, 16'hffaa);
        apb(16'hffcb, 1, 8'h01);
        apb(16'hffd5, 1, 8'hab);
        @(negedge pclk);
        chk({poe, pout}, 16'hfeaa);
        apb(16'hffcb, 1, 0);
        apb(16'hffc9, 1, 8'h0f);
        @(negedge pclk);
        chk({i0, po, cd, i4, poe[1:0], pout[0]}, 7'h7b);
        apb(16'hffe0, 1, 8'hff);
        apb(16'hffe4, 1, 8'h0f);
        @(negedge pclk);
        chk(pu, 8'hf0);
        apb(16'hffe8, 1, 8'h01);
        repeat (2) @(negedge pclk);
        chk(sh, 8'hc0);
        apb(16'hff00, 0, 0);
        chk({rd[30:0], err}, 1);
        $display("pin test done");
        end_sim;
    end
endmodule
